/* inc/wpt_pkg.sv */
// Constants, register map and types of the watchdog / power-fail timer
package wpt_pkg;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_THRESH = 8'h04;
  localparam logic [7:0] ADR_SUBCNT = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_COUNT = 8'h10;
  localparam logic [7:0] ADR_PRESC = 8'h14;

  // Control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_PF_MODE = 1;
  localparam int CTRL_CLK_LO = 2;
  localparam int CTRL_CLK_HI = 3;
  localparam int CTRL_PIN_EN = 4;
  localparam int CTRL_INT_MODE = 5;
  // Status field positions
  localparam int STAT_FLAG = 0;
  localparam int STAT_PIN = 1;
  localparam int STAT_FSM_LO = 2;
  localparam int STAT_FSM_HI = 4;

  // Values after reset and fixed count values
  localparam logic [7:0] THRESH_RST = 8'h00;
  localparam logic [7:0] SUBCNT_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] PRESC_RST = 8'h01;
  localparam logic [7:0] COUNT_START = 8'h01;
  localparam logic [7:0] PF_END = 8'hff;
  localparam logic [1:0] CLK_OFF = 2'h0;
  localparam logic [1:0] CLK_SEL1 = 2'h1;
  localparam logic [1:0] CLK_SEL2 = 2'h2;

  // Default prescaler overflow counts when the sub-count register is zero
  localparam logic [7:0] DEF_SUB_1 = 8'h15;
  localparam logic [7:0] DEF_SUB_2 = 8'h01;
  localparam logic [7:0] DEF_SUB_3 = 8'h01;

  // Timing: mclk at 100 MHz
  localparam longint unsigned CYC_PER_MS = 64'd100000;
  localparam longint unsigned TCLK1_MS = 64'd10;
  localparam longint unsigned TCLK2_MS = 64'd1000;
  localparam longint unsigned TCLK3_MS = 64'd60000;
  localparam longint unsigned PULSE_MS = 64'd210;
  localparam longint unsigned TCLK1_CYC_L = TCLK1_MS * CYC_PER_MS;
  localparam longint unsigned TCLK2_CYC_L = TCLK2_MS * CYC_PER_MS;
  localparam longint unsigned TCLK3_CYC_L = TCLK3_MS * CYC_PER_MS;
  localparam longint unsigned PULSE_CYC_L = PULSE_MS * CYC_PER_MS;
  localparam logic [35:0] TCLK1_CYC = TCLK1_CYC_L[35:0];
  localparam logic [35:0] TCLK2_CYC = TCLK2_CYC_L[35:0];
  localparam logic [35:0] TCLK3_CYC = TCLK3_CYC_L[35:0];
  localparam logic [35:0] PULSE_CYC = PULSE_CYC_L[35:0];

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ARMED,
    ST_RUN,
    ST_HALT
  } wpt_fsm_t;

  // Software settings
  typedef struct packed {
    logic en;
    logic pf_mode;
    logic [1:0] clk_sel;
    logic pin_en;
    logic int_mode;
    logic [7:0] thresh;
    logic [7:0] sub;
  } wpt_cfg_t;

  // Start detector state
  typedef struct packed {
    logic sda_meta;
    logic scl_meta;
    logic sda_sync;
    logic scl_sync;
    logic sda_prev;
    logic start;
  } wpt_det_t;

  // Timer state
  typedef struct packed {
    wpt_fsm_t fsm;
    wpt_cfg_t cfg;
    logic flag;
    logic pin_n;
    logic [7:0] cnt;
    logic [7:0] presc;
    logic [35:0] tick_cnt;
    logic [35:0] pulse_cnt;
    logic pulse_on;
    logic pausing;
    logic batt_q;
    logic en_q;
    logic ack;
    logic [31:0] rdata;
  } wpt_state_t;

endpackage : wpt_pkg

/* hw/wpt_start_det.sv */
// Serial bus START detector with two-flop synchronisers
`timescale 1ns/10ps
module wpt_start_det (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sda_in,
  input wire logic scl_in,
  input wire logic powerup_busy,
  output logic start_pulse
);

  wpt_pkg::wpt_det_t s;
  wpt_pkg::wpt_det_t next_s;

  always_comb begin
    next_s = s;
    next_s.sda_meta = sda_in;
    next_s.scl_meta = scl_in;
    next_s.sda_sync = s.sda_meta;
    next_s.scl_sync = s.scl_meta;
    next_s.sda_prev = s.sda_sync;
    // Data falls while clock high, not during power-up
    next_s.start = s.sda_prev & ~s.sda_sync & s.scl_sync
                   & ~powerup_busy;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '{sda_meta: 1'b1, scl_meta: 1'b1, sda_sync: 1'b1,
             scl_sync: 1'b1, sda_prev: 1'b1, start: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign start_pulse = s.start;

endmodule : wpt_start_det

/* hw/wpt_timer.sv */
// Watchdog and power-fail timer with a classic Wishbone register slave
`timescale 1ns/10ps
module wpt_timer #(
  parameter logic [35:0] TCLK1_CYC = wpt_pkg::TCLK1_CYC,
  parameter logic [35:0] TCLK2_CYC = wpt_pkg::TCLK2_CYC,
  parameter logic [35:0] TCLK3_CYC = wpt_pkg::TCLK3_CYC,
  parameter logic [35:0] PULSE_CYC = wpt_pkg::PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sda_in,
  input wire logic scl_in,
  input wire logic powerup_busy,
  input wire logic battery_mode,
  output logic timer_interrupt_pin_n,
  output logic timer_status_flag
);

  wpt_pkg::wpt_state_t s;
  wpt_pkg::wpt_state_t next_s;
  logic start_pulse;

  wpt_start_det u_start_det (
    .mclk(mclk),
    .rst(rst),
    .sda_in(sda_in),
    .scl_in(scl_in),
    .powerup_busy(powerup_busy),
    .start_pulse(start_pulse)
  );

  // Helper terms
  logic req;
  logic clear_req;
  logic run_en;
  logic run_rise;
  logic batt_rise;
  logic [35:0] tick_len;
  logic [7:0] sub_eff;
  logic counting;
  logic tick;
  logic ovf;

  always_comb begin
    unique case (s.cfg.clk_sel)
      wpt_pkg::CLK_OFF: begin
        tick_len = TCLK1_CYC;
        sub_eff = wpt_pkg::DEF_SUB_1;
      end
      wpt_pkg::CLK_SEL1: begin
        tick_len = TCLK1_CYC;
        sub_eff = wpt_pkg::DEF_SUB_1;
      end
      wpt_pkg::CLK_SEL2: begin
        tick_len = TCLK2_CYC;
        sub_eff = wpt_pkg::DEF_SUB_2;
      end
      default: begin
        tick_len = TCLK3_CYC;
        sub_eff = wpt_pkg::DEF_SUB_3;
      end
    endcase
    if (s.cfg.sub != 8'h00) begin
      sub_eff = s.cfg.sub;
    end
  end

  assign req = wb_cyc_i & wb_stb_i & ~s.ack;
  assign clear_req = req & wb_we_i & wb_sel_i[0]
                     & (wb_adr_i == wpt_pkg::ADR_STATUS)
                     & wb_dat_i[wpt_pkg::STAT_FLAG];
  assign run_en = s.cfg.en & (s.cfg.clk_sel != wpt_pkg::CLK_OFF);
  assign run_rise = run_en & ~s.en_q;
  assign batt_rise = battery_mode & ~s.batt_q;
  assign counting = (s.fsm == wpt_pkg::ST_RUN) & ~s.pausing;
  assign tick = counting & (s.tick_cnt == tick_len - 36'h1);
  assign ovf = tick & (s.presc == sub_eff);

  always_comb begin
    next_s = s;
    next_s.ack = 1'b0;
    next_s.batt_q = battery_mode;
    next_s.en_q = run_en;

    // Register slave: one wait state, ack for one cycle
    if (req) begin
      next_s.ack = 1'b1;
      next_s.rdata = 32'h0000_0000;
      if (wb_we_i) begin
        if (wb_sel_i[0]) begin
          unique case (wb_adr_i)
            wpt_pkg::ADR_CTRL: begin
              next_s.cfg.en = wb_dat_i[wpt_pkg::CTRL_EN];
              next_s.cfg.pf_mode = wb_dat_i[wpt_pkg::CTRL_PF_MODE];
              next_s.cfg.clk_sel =
                wb_dat_i[wpt_pkg::CTRL_CLK_HI:wpt_pkg::CTRL_CLK_LO];
              next_s.cfg.pin_en = wb_dat_i[wpt_pkg::CTRL_PIN_EN];
              next_s.cfg.int_mode = wb_dat_i[wpt_pkg::CTRL_INT_MODE];
            end
            wpt_pkg::ADR_THRESH: next_s.cfg.thresh = wb_dat_i[7:0];
            wpt_pkg::ADR_SUBCNT: next_s.cfg.sub = wb_dat_i[7:0];
            default: begin
            end
          endcase
        end
      end else begin
        unique case (wb_adr_i)
          wpt_pkg::ADR_CTRL: begin
            next_s.rdata[wpt_pkg::CTRL_EN] = s.cfg.en;
            next_s.rdata[wpt_pkg::CTRL_PF_MODE] = s.cfg.pf_mode;
            next_s.rdata[wpt_pkg::CTRL_CLK_HI:wpt_pkg::CTRL_CLK_LO] =
              s.cfg.clk_sel;
            next_s.rdata[wpt_pkg::CTRL_PIN_EN] = s.cfg.pin_en;
            next_s.rdata[wpt_pkg::CTRL_INT_MODE] = s.cfg.int_mode;
          end
          wpt_pkg::ADR_THRESH: next_s.rdata[7:0] = s.cfg.thresh;
          wpt_pkg::ADR_SUBCNT: next_s.rdata[7:0] = s.cfg.sub;
          wpt_pkg::ADR_STATUS: begin
            next_s.rdata[wpt_pkg::STAT_FLAG] = s.flag;
            next_s.rdata[wpt_pkg::STAT_PIN] = s.pin_n;
            next_s.rdata[wpt_pkg::STAT_FSM_HI:wpt_pkg::STAT_FSM_LO] = s.fsm;
          end
          wpt_pkg::ADR_COUNT: next_s.rdata[7:0] = s.cnt;
          wpt_pkg::ADR_PRESC: next_s.rdata[7:0] = s.presc;
          default: begin
          end
        endcase
      end
    end

    // Flag clear first so that a same-cycle expiry wins
    if (clear_req) begin
      next_s.flag = 1'b0;
    end

    // Cycle-rate tick and prescaler
    if (counting) begin
      next_s.tick_cnt = tick ? 36'h0 : s.tick_cnt + 36'h1;
      if (tick) begin
        next_s.presc = ovf ? wpt_pkg::PRESC_RST
                           : s.presc + 8'h01;
      end
    end

    // 210 ms window after a watchdog expiry
    if (s.pulse_on) begin
      next_s.pulse_cnt = s.pulse_cnt + 36'h1;
      if (s.pulse_cnt == PULSE_CYC - 36'h1) begin
        next_s.pulse_on = 1'b0;
        next_s.pausing = 1'b0;
        next_s.pin_n = 1'b1;
      end
    end

    unique case (s.fsm)
      wpt_pkg::ST_OFF: begin
        if (run_rise) begin
          if (s.cfg.pf_mode) begin
            next_s.fsm = wpt_pkg::ST_ARMED;
          end else if (s.cfg.thresh >= 8'h01) begin
            next_s.fsm = wpt_pkg::ST_RUN;
            next_s.cnt = wpt_pkg::COUNT_START;
            next_s.presc = wpt_pkg::PRESC_RST;
            next_s.tick_cnt = 36'h0;
          end
        end
      end
      wpt_pkg::ST_ARMED: begin
        if (batt_rise) begin
          next_s.fsm = wpt_pkg::ST_RUN;
          if (s.cnt == wpt_pkg::COUNT_RST) begin
            next_s.cnt = wpt_pkg::COUNT_START;
          end
        end
      end
      wpt_pkg::ST_RUN: begin
        if (s.cfg.pf_mode) begin
          if (!battery_mode) begin
            next_s.fsm = wpt_pkg::ST_ARMED;
            next_s.tick_cnt = s.tick_cnt;
            next_s.presc = s.presc;
          end else if (ovf) begin
            next_s.cnt = s.cnt + 8'h01;
            if (s.cnt + 8'h01 == wpt_pkg::PF_END) begin
              next_s.flag = 1'b1;
              next_s.pin_n = ~s.cfg.pin_en;
              next_s.fsm = wpt_pkg::ST_HALT;
            end
          end
        end else if (start_pulse) begin
          next_s.cnt = wpt_pkg::COUNT_START;
          next_s.presc = wpt_pkg::PRESC_RST;
          next_s.tick_cnt = 36'h0;
          next_s.pausing = 1'b0;
        end else if (ovf) begin
          if (s.pulse_on && !s.pin_n) begin
            // Low phase ends at one sub-period; rest of window stalls
            next_s.pin_n = 1'b1;
            next_s.pausing = 1'b1;
          end else if (s.pulse_on) begin
            next_s.pausing = 1'b1;
          end
          if (s.cnt == s.cfg.thresh) begin
            next_s.flag = 1'b1;
            next_s.cnt = wpt_pkg::COUNT_START;
            next_s.pulse_on = 1'b1;
            next_s.pulse_cnt = 36'h0;
            next_s.pausing = 1'b0;
            next_s.pin_n = ~s.cfg.pin_en;
          end else begin
            next_s.cnt = s.cnt + 8'h01;
          end
        end
      end
      wpt_pkg::ST_HALT: begin
        if (clear_req) begin
          next_s.pin_n = 1'b1;
          next_s.cnt = wpt_pkg::COUNT_START;
          next_s.presc = wpt_pkg::PRESC_RST;
          next_s.tick_cnt = 36'h0;
          next_s.fsm = battery_mode ? wpt_pkg::ST_RUN
                                    : wpt_pkg::ST_ARMED;
        end
      end
    endcase

    // Disable: count, prescaler and tick counter to defaults, pulse window ended, pin released, flag untouched
    if (!run_en) begin
      next_s.fsm = wpt_pkg::ST_OFF;
      next_s.cnt = wpt_pkg::COUNT_RST;
      next_s.presc = wpt_pkg::PRESC_RST;
      next_s.tick_cnt = 36'h0;
      next_s.pulse_on = 1'b0;
      next_s.pausing = 1'b0;
      next_s.pin_n = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '{fsm: wpt_pkg::ST_OFF,
             cfg: '{en: 1'b0, pf_mode: 1'b0, clk_sel: wpt_pkg::CLK_OFF,
                    pin_en: 1'b0, int_mode: 1'b0,
                    thresh: wpt_pkg::THRESH_RST,
                    sub: wpt_pkg::SUBCNT_RST},
             flag: 1'b0,
             pin_n: 1'b1,
             cnt: wpt_pkg::COUNT_RST,
             presc: wpt_pkg::PRESC_RST,
             tick_cnt: 36'h0,
             pulse_cnt: 36'h0,
             pulse_on: 1'b0,
             pausing: 1'b0,
             batt_q: 1'b0,
             en_q: 1'b0,
             ack: 1'b0,
             rdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign timer_interrupt_pin_n = s.pin_n;
  assign timer_status_flag = s.flag;

endmodule : wpt_timer

/* verification/wpt_timer_properties.sv */
// Checker for the timer's bus handshake and interrupt outputs
`timescale 1ns/10ps
module wpt_timer_properties #(
  parameter logic [35:0] PULSE_CYC = wpt_pkg::PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timer_interrupt_pin_n,
  input wire logic timer_status_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic req;
  logic clr;
  logic wr_ctrl;
  logic [7:0] ctrl;
  logic [35:0] low_cnt;
  logic [3:0] off_cnt;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign clr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] &&
    wb_dat_i[0] && wb_adr_i == wpt_pkg::ADR_STATUS;
  assign wr_ctrl = req && wb_we_i && wb_sel_i[0] &&
    wb_adr_i == wpt_pkg::ADR_CTRL;
  // Shadow control byte, low time and disabled time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= 8'h00;
      low_cnt <= 36'h0;
      off_cnt <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wb_dat_i[7:0];
      end
      low_cnt <= timer_interrupt_pin_n ? 36'h0 : low_cnt + 36'h1;
      off_cnt <= (ctrl[0] && ctrl[3:2] != 2'h0) ? 4'h0 :
        off_cnt + 4'(off_cnt != 4'hf);
    end
  end
  AST_ACK_ANSWER: assert property (req |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_SINGLE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_RD_UNMAPPED: assert property (
    req && !wb_we_i && wb_adr_i > wpt_pkg::ADR_PRESC |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_FLAG_KEPT: assert property (
    timer_status_flag && !clr |=> timer_status_flag)
    else $error("flag dropped");
  AST_PIN_FLAG: assert property (
    $fell(timer_interrupt_pin_n) |-> ##[0:1] timer_status_flag)
    else $error("pin low without flag");
  AST_PULSE_CAP: assert property (
    ctrl[0] && !ctrl[1] |-> low_cnt <= PULSE_CYC)
    else $error("watchdog pulse too long");
  AST_OFF_QUIET: assert property (
    off_cnt > 4'h3 |-> timer_interrupt_pin_n && !$rose(timer_status_flag))
    else $error("disabled timer active");
  AST_OFF_RELEASE: assert property (
    wr_ctrl && !wb_dat_i[0] |-> ##[1:4] timer_interrupt_pin_n)
    else $error("pin not released");
  cover property ($fell(timer_interrupt_pin_n));
  cover property (clr && timer_status_flag);
  cover property (low_cnt == PULSE_CYC);
endmodule : wpt_timer_properties

bind wpt_timer wpt_timer_properties #(.PULSE_CYC(PULSE_CYC)) u_props (
  .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timer_interrupt_pin_n(timer_interrupt_pin_n),
  .timer_status_flag(timer_status_flag));

/* verification/wpt_bus_model.sv */
// Serial bus master and supply switchover model
`timescale 1ns/10ps
module wpt_bus_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic fake,
  input wire logic batt_req,
  output logic sda,
  output logic scl,
  output logic battery_mode,
  output logic busy
);
  logic [3:0] step = 4'h0;
  logic odd = 1'h0;
  always @(posedge mclk) begin
    battery_mode <= batt_req;
    if (step != 4'h0) begin
      step <= (step == 4'hb) ? 4'h0 : step + 4'h1;
    end else if (go) begin
      step <= 4'h1;
      odd <= fake;
    end
  end
  // Lines rest high on pull-ups; fake drops data with clock low
  assign busy = step != 4'h0;
  assign sda = !(step >= 4'h3 && step < 4'ha);
  assign scl = odd ? !(step >= 4'h2 && step < 4'h8) :
    !(step >= 4'h5 && step < 4'h8);
endmodule : wpt_bus_model

/* verification/wpt_timer_tb_top.sv */
// Self-checking bench for the watchdog and power-fail timer
`timescale 1ns/10ps
module wpt_timer_tb_top;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [3:0] s;
    logic [31:0] d;
    logic [31:0] e;
  } wpt_row_t;
  localparam wpt_row_t ROWS [12] = '{
    '{1'h0, 8'h00, 4'hf, 32'h0, 32'h0}, '{1'h0, 8'h04, 4'hf, 32'h0, 32'h0},
    '{1'h0, 8'h08, 4'hf, 32'h0, 32'h0}, '{1'h0, 8'h0c, 4'hf, 32'h0, 32'h2},
    '{1'h0, 8'h10, 4'hf, 32'h0, 32'h0}, '{1'h0, 8'h14, 4'hf, 32'h0, 32'h1},
    '{1'h1, 8'h04, 4'hf, 32'hffffff5a, 32'h0},
    '{1'h0, 8'h04, 4'hf, 32'h0, 32'h5a}, '{1'h1, 8'h04, 4'he, 32'h11, 32'h0},
    '{1'h0, 8'h04, 4'hf, 32'h0, 32'h5a}, '{1'h1, 8'h20, 4'hf, 32'hff, 32'h0},
    '{1'h0, 8'h20, 4'hf, 32'h0, 32'h0}};
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic powerup_busy = 1'h0;
  logic go = 1'h0;
  logic fake = 1'h0;
  logic batt_req = 1'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic wb_ack_o, sda, scl, batt, busy, pin_n, flag;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  int c0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  wpt_timer #(.TCLK1_CYC(36'h14), .TCLK2_CYC(36'h1e), .TCLK3_CYC(36'h28),
    .PULSE_CYC(36'h32)) u_dut (.mclk(mclk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sda_in(sda), .scl_in(scl),
    .powerup_busy(powerup_busy), .battery_mode(batt),
    .timer_interrupt_pin_n(pin_n), .timer_status_flag(flag));
  wpt_bus_model u_bus (.mclk(mclk), .go(go), .fake(fake),
    .batt_req(batt_req), .sda(sda), .scl(scl), .battery_mode(batt),
    .busy(busy));
  task automatic finish_test();
    $display("TB: checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input int v, input int lo, input int hi);
    chk(32'(v >= lo && v <= hi), 32'h1);
  endtask : rng
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d = 32'h0, input logic [3:0] s = 4'hf);
    int k;
    k = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack_o !== 1'h1 && k < 16);
    q = wb_dat_o;
    if (k == 16) fails++;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge mclk);
  endtask : bus
  task automatic frame(input logic f);
    int k;
    k = 0;
    go <= 1'h1;
    fake <= f;
    @(posedge mclk);
    go <= 1'h0;
    do begin
      @(posedge mclk);
      k++;
    end while (busy === 1'h1 && k < 20);
  endtask : frame
  task automatic span(input logic lv);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pin_n === lv && n < 9000);
  endtask : span
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge mclk);
    chk(32'(pin_n), 32'h1);
    chk(32'(flag), 32'h0);
    rst <= 1'h0;
    @(posedge mclk);
    for (int i = 0; i < 12; i++) begin
      bus(ROWS[i].w, ROWS[i].a, ROWS[i].d, ROWS[i].s);
      if (!ROWS[i].w) chk(q, ROWS[i].e);
    end
    bus(1'h1, 8'h08, 32'h2);
    bus(1'h1, 8'h04, 32'h3);
    bus(1'h1, 8'h00, 32'h15);
    span(1'h1);
    rng(n, 117, 123);
    span(1'h0);
    rng(n, 39, 41);
    span(1'h1);
    rng(n, 89, 91);
    bus(1'h0, 8'h0c);
    chk(q & 32'h1, 32'h1);
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h0, 8'h10);
    chk(q, 32'h0);
    bus(1'h0, 8'h14);
    chk(q, 32'h1);
    bus(1'h1, 8'h08, 32'h0);
    bus(1'h1, 8'h04, 32'h1);
    bus(1'h1, 8'h00, 32'h15);
    span(1'h1);
    rng(n, 417, 423);
    span(1'h0);
    rng(n, 49, 51);
    bus(1'h1, 8'h08, 32'h1);
    for (int s = 1; s < 4; s++) begin
      bus(1'h1, 8'h00, 32'h0);
      bus(1'h1, 8'h00, 32'(8'h11 | (s << 2)));
      span(1'h1);
      rng(n, 10 * s + 7, 10 * s + 13);
    end
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h1, 8'h04, 32'h0);
    bus(1'h1, 8'h00, 32'h15);
    bus(1'h1, 8'h04, 32'h1);
    repeat (100) @(posedge mclk);
    bus(1'h0, 8'h10);
    chk(q, 32'h0);
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h1, 8'h00, 32'h11);
    repeat (100) @(posedge mclk);
    bus(1'h0, 8'h10);
    chk(q, 32'h0);
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h1, 8'h0c, 32'h1);
    bus(1'h1, 8'h08, 32'h2);
    bus(1'h1, 8'h04, 32'h3);
    bus(1'h1, 8'h00, 32'h15);
    repeat (5) begin
      repeat (60) @(posedge mclk);
      frame(1'h0);
    end
    bus(1'h0, 8'h0c);
    chk(q & 32'h1, 32'h0);
    c0 = cyc;
    frame(1'h1);
    powerup_busy <= 1'h1;
    frame(1'h0);
    powerup_busy <= 1'h0;
    span(1'h1);
    rng(cyc - c0, 105, 120);
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h1, 8'h0c, 32'h1);
    bus(1'h1, 8'h08, 32'h1);
    bus(1'h1, 8'h00, 32'h17);
    repeat (60) @(posedge mclk);
    batt_req <= 1'h1;
    repeat (1000) @(posedge mclk);
    batt_req <= 1'h0;
    bus(1'h0, 8'h10);
    rng(int'(q), 50, 52);
    repeat (200) @(posedge mclk);
    bus(1'h0, 8'h10);
    rng(int'(q), 50, 52);
    batt_req <= 1'h1;
    span(1'h1);
    rng(n + 1000, 5070, 5090);
    repeat (100) @(posedge mclk);
    chk(32'(pin_n), 32'h0);
    bus(1'h0, 8'h10);
    chk(q, 32'hff);
    bus(1'h1, 8'h0c, 32'h1);
    repeat (2) @(posedge mclk);
    chk(32'(pin_n), 32'h1);
    bus(1'h0, 8'h10);
    rng(int'(q), 1, 2);
    bus(1'h1, 8'h00, 32'h0);
    bus(1'h0, 8'h10);
    chk(q, 32'h0);
    bus(1'h1, 8'h00, 32'h15);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    chk(32'(pin_n), 32'h1);
    chk(32'(flag), 32'h0);
    rst <= 1'h0;
    @(posedge mclk);
    bus(1'h0, 8'h00);
    chk(q, 32'h0);
    finish_test();
  end
endmodule : wpt_timer_tb_top
